// File: hw/timer_pkg.sv
package timer_pkg;

  typedef enum logic [1:0] {VARIANT_ADVANCED, VARIANT_GENERAL, VARIANT_BASIC} variant_type;

  // register byte offsets
  localparam logic [5:0] OFS_CONTROL = 6'h00;
  localparam logic [5:0] OFS_PRESCALE = 6'h04;
  localparam logic [5:0] OFS_RELOAD = 6'h08;
  localparam logic [5:0] OFS_COUNT = 6'h0c;
  localparam logic [5:0] OFS_STATUS = 6'h10;
  localparam logic [5:0] OFS_MASK = 6'h14;
  localparam logic [5:0] OFS_CHAN_MODE = 6'h18;
  localparam logic [5:0] OFS_DEADTIME = 6'h1c;
  localparam logic [5:0] OFS_CCR0 = 6'h20;

  // control fields
  localparam int CTL_ENABLE = 0;
  localparam int CTL_DOWN = 1;
  localparam int CTL_CENTER = 2;
  localparam int CTL_ONE_PULSE = 3;
  localparam int CTL_SLAVE_LSB = 4;
  localparam int CTL_FREEZE = 7;
  localparam int CTL_OUT_ENABLE = 8;

  // slave modes, control[6:4]
  localparam logic [2:0] SLAVE_FREE = 3'h0;
  localparam logic [2:0] SLAVE_ENCODER = 3'h1;
  localparam logic [2:0] SLAVE_HALL = 3'h2;
  localparam logic [2:0] SLAVE_RESET = 3'h3;
  localparam logic [2:0] SLAVE_GATED = 3'h4;
  localparam logic [2:0] SLAVE_START = 3'h5;
  localparam logic [2:0] SLAVE_EXT_CLOCK = 3'h6;

  // channel mode: four bits per channel, mode in [1:0], polarity in [2]
  localparam int CHAN_FIELD = 4;
  localparam int CHAN_POL = 2;
  localparam logic [1:0] CHAN_OFF = 2'h0;
  localparam logic [1:0] CHAN_CAPTURE = 2'h1;
  localparam logic [1:0] CHAN_COMPARE = 2'h2;
  localparam logic [1:0] CHAN_PWM = 2'h3;

  // status and mask bits
  localparam int STAT_UPDATE = 0;
  localparam int STAT_CHAN_LSB = 1;
  localparam int STAT_TRIGGER = 5;
  localparam int STAT_WIDTH = 6;

  // reset values
  localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
  localparam logic [15:0] RST_PRESCALE = 16'h0001;
  localparam logic [31:0] RST_RELOAD = 32'hffff_ffff;
  localparam logic [7:0] RST_DEADTIME = 8'h00;

  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avalon_req_type;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avalon_rsp_type;

  typedef struct packed {
    logic adc_regular;
    logic adc_injected;
    logic dac;
  } conv_trig_type;

endpackage

// File: hw/pwm_timer.sv
// The Avalon-MM interface to the registers and the address map were decided locally.
module pwm_timer #(
  parameter timer_pkg::variant_type VARIANT = timer_pkg::VARIANT_ADVANCED
) (
  input wire logic clk, // 25 MHz clock
  input wire logic sys_rst, // synchronous reset, high
  input wire timer_pkg::avalon_req_type bus_req, // avalon-mm request
  output timer_pkg::avalon_rsp_type bus_rsp, // avalon-mm answer
  input wire logic [3:0] chan_in, // channel pins, encoder a/b, hall
  input wire logic trig_in, // event from another timer
  input wire logic debug_halt, // processor halted for debug
  output logic [3:0] out_high, // channel outputs, high side
  output logic [2:0] out_low, // complementary outputs, advanced
  output logic trig_out, // update pulse to other timers
  output timer_pkg::conv_trig_type conv_trig, // converter triggers
  output logic irq // level interrupt
);
  import timer_pkg::*;

  typedef struct packed {
    logic [31:0] control;
    logic [15:0] prescale;
    logic [31:0] reload;
    logic [31:0] count;
    logic [STAT_WIDTH-1:0] status;
    logic [STAT_WIDTH-1:0] mask;
    logic [15:0] chan_mode;
    logic [7:0] deadtime;
    logic [3:0][31:0] ccr;
    logic [15:0] psc_cnt;
    logic phase_down;
    logic [3:0] in_meta;
    logic [3:0] in_sync;
    logic [3:0] in_prev;
    logic trig_meta;
    logic trig_sync;
    logic trig_prev;
    logic halt_meta;
    logic halt_sync;
    logic [3:0] ref_level;
    logic [2:0][7:0] dt_cnt;
    logic [3:0] out_high;
    logic [2:0] out_low;
    logic trig_out;
    conv_trig_type conv;
    logic irq;
    avalon_rsp_type rsp;
  } state_type;

  localparam bit HAS_CHAN = (VARIANT != VARIANT_BASIC);

  state_type state;
  state_type next_state;
  logic taken;
  logic frozen;
  logic [2:0] slave;
  logic trig_rise;
  logic hall_evt;
  logic enc_step;
  logic enc_up;
  logic [15:0] psc_eff;
  logic psc_adv;
  logic tick;
  logic center;
  logic down_dir;
  logic cnt_override;
  logic update_evt;
  logic [3:0] chan_evt;
  logic [1:0] cmode;
  logic cpol;
  logic dt_done;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        r[b*8 +: 8] = wd[b*8 +: 8];
    end
    return r;
  endfunction

  always_comb
  begin
    next_state = state;
    taken = (bus_req.read || bus_req.write) && !state.rsp.waitrequest;
    // pins pass two flops before use
    next_state.in_meta = chan_in;
    next_state.in_sync = state.in_meta;
    next_state.in_prev = state.in_sync;
    next_state.trig_meta = trig_in;
    next_state.trig_sync = state.trig_meta;
    next_state.trig_prev = state.trig_sync;
    next_state.halt_meta = debug_halt;
    next_state.halt_sync = state.halt_meta;

    frozen = (VARIANT == VARIANT_ADVANCED) && state.control[CTL_FREEZE] && state.halt_sync;
    slave = HAS_CHAN ? state.control[CTL_SLAVE_LSB +: 3] : SLAVE_FREE;
    trig_rise = state.trig_sync && !state.trig_prev;
    hall_evt = (VARIANT == VARIANT_GENERAL) && (slave == SLAVE_HALL)
               && ((^state.in_sync[2:0]) != (^state.in_prev[2:0]));
    enc_step = (VARIANT == VARIANT_GENERAL) && (slave == SLAVE_ENCODER)
               && ((state.in_sync[0] ^ state.in_prev[0]) != (state.in_sync[1] ^ state.in_prev[1]));
    enc_up = !(state.in_prev[0] ^ state.in_sync[1]);

    // prescaler; a zero setting behaves as one
    psc_eff = (state.prescale == 16'h0000) ? 16'h0001 : state.prescale;
    if (slave == SLAVE_GATED)
      psc_adv = state.trig_sync;
    else if (slave == SLAVE_EXT_CLOCK)
      psc_adv = trig_rise;
    else if (slave == SLAVE_ENCODER)
      psc_adv = 1'b0;
    else
      psc_adv = 1'b1;
    psc_adv = psc_adv && state.control[CTL_ENABLE] && !frozen;
    tick = 1'b0;
    if (psc_adv)
    begin
      if (state.psc_cnt >= psc_eff - 16'h0001)
      begin
        next_state.psc_cnt = 16'h0000;
        tick = 1'b1;
      end
      else
        next_state.psc_cnt = state.psc_cnt + 16'h0001;
    end
    if (enc_step && state.control[CTL_ENABLE] && !frozen)
      tick = 1'b1;

    // basic variant never counts down
    center = HAS_CHAN && state.control[CTL_CENTER] && (slave != SLAVE_ENCODER);
    if (!HAS_CHAN)
      down_dir = 1'b0;
    else if (slave == SLAVE_ENCODER)
      down_dir = !enc_up;
    else if (center)
      down_dir = state.phase_down;
    else
      down_dir = state.control[CTL_DOWN];

    update_evt = 1'b0;
    if (tick)
    begin
      if (center && !state.phase_down && state.count >= state.reload)
      begin
        next_state.phase_down = (state.reload != 32'h0000_0000);
        next_state.count = (state.reload == 32'h0000_0000) ? 32'h0 : state.reload - 32'h1;
        update_evt = 1'b1;
      end
      else if (center && state.phase_down && state.count == 32'h0000_0000)
      begin
        next_state.phase_down = 1'b0;
        next_state.count = (state.reload == 32'h0000_0000) ? 32'h0 : 32'h1;
        update_evt = 1'b1;
      end
      else if (down_dir && state.count == 32'h0000_0000)
      begin
        next_state.count = state.reload;
        update_evt = 1'b1;
      end
      else if (!down_dir && state.count >= state.reload)
      begin
        next_state.count = 32'h0000_0000;
        update_evt = 1'b1;
      end
      else if (down_dir)
        next_state.count = state.count - 32'h1;
      else
        next_state.count = state.count + 32'h1;
    end

    // reset from trigger or hall edge restarts the period
    cnt_override = 1'b0;
    if (((slave == SLAVE_RESET) && trig_rise) || hall_evt)
    begin
      cnt_override = 1'b1;
      next_state.count = 32'h0000_0000;
      next_state.psc_cnt = 16'h0000;
      next_state.phase_down = 1'b0;
    end
    if ((slave == SLAVE_START) && trig_rise)
      next_state.control[CTL_ENABLE] = 1'b1;
    if (update_evt && state.control[CTL_ONE_PULSE])
      next_state.control[CTL_ENABLE] = 1'b0;

    // channels
    chan_evt = 4'h0;
    cmode = CHAN_OFF;
    cpol = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      cmode = HAS_CHAN ? state.chan_mode[i*CHAN_FIELD +: 2] : CHAN_OFF;
      cpol = state.chan_mode[i*CHAN_FIELD + CHAN_POL];
      case (cmode)
        CHAN_CAPTURE:
        begin
          if ((i == 0 && hall_evt) || (slave != SLAVE_HALL && (cpol ?
              (state.in_prev[i] && !state.in_sync[i]) : (!state.in_prev[i] && state.in_sync[i]))))
          begin
            next_state.ccr[i] = state.count;
            chan_evt[i] = 1'b1;
          end
          next_state.ref_level[i] = 1'b0;
        end
        CHAN_COMPARE:
        begin
          if (tick && state.count == state.ccr[i])
          begin
            next_state.ref_level[i] = !state.ref_level[i];
            chan_evt[i] = 1'b1;
          end
        end
        CHAN_PWM:
        begin
          // level follows the count, so center mode is symmetric
          next_state.ref_level[i] = state.control[CTL_ENABLE]
                                    && ((state.count < state.ccr[i]) ^ cpol);
          if (tick && state.count == state.ccr[i])
            chan_evt[i] = 1'b1;
        end
        default:
          next_state.ref_level[i] = 1'b0;
      endcase
    end

    // dead time, advanced variant only: both sides stay off until the pair's counter expires
    dt_done = 1'b0;
    for (int j = 0; j < 3; j++)
    begin
      if (next_state.ref_level[j] != state.ref_level[j])
        next_state.dt_cnt[j] = 8'h00;
      else if (state.dt_cnt[j] < state.deadtime)
        next_state.dt_cnt[j] = state.dt_cnt[j] + 8'h01;
      dt_done = (next_state.dt_cnt[j] >= state.deadtime);
      if (VARIANT == VARIANT_ADVANCED)
      begin
        next_state.out_high[j] = next_state.ref_level[j] && dt_done;
        next_state.out_low[j] = !next_state.ref_level[j] && dt_done;
      end
      else
      begin
        next_state.out_high[j] = next_state.ref_level[j];
        next_state.out_low[j] = 1'b0;
      end
    end
    next_state.out_high[3] = next_state.ref_level[3];
    if (!state.control[CTL_OUT_ENABLE] || frozen)
    begin
      next_state.out_high = 4'h0;
      next_state.out_low = 3'h0;
    end
    if (frozen)
    begin
      next_state.count = state.count;
      next_state.psc_cnt = state.psc_cnt;
    end

    // chaining and converter routing
    next_state.trig_out = update_evt;
    next_state.conv.adc_regular = (VARIANT == VARIANT_GENERAL) && update_evt;
    next_state.conv.adc_injected = (VARIANT == VARIANT_ADVANCED) && update_evt;
    next_state.conv.dac = (VARIANT == VARIANT_BASIC) && update_evt;

    // bus: answer one cycle after the request is seen
    next_state.rsp.waitrequest = !((bus_req.read || bus_req.write) && state.rsp.waitrequest);
    if (bus_req.read && state.rsp.waitrequest)
    begin
      next_state.rsp.readdata = 32'h0000_0000;
      if (bus_req.address == OFS_CONTROL)
        next_state.rsp.readdata = state.control;
      else if (bus_req.address == OFS_PRESCALE)
        next_state.rsp.readdata = {16'h0000, state.prescale};
      else if (bus_req.address == OFS_RELOAD)
        next_state.rsp.readdata = state.reload;
      else if (bus_req.address == OFS_COUNT)
        next_state.rsp.readdata = state.count;
      else if (bus_req.address == OFS_STATUS)
        next_state.rsp.readdata = {26'h0, state.status};
      else if (bus_req.address == OFS_MASK)
        next_state.rsp.readdata = {26'h0, state.mask};
      else if (bus_req.address == OFS_CHAN_MODE)
        next_state.rsp.readdata = {16'h0000, state.chan_mode};
      else if (bus_req.address == OFS_DEADTIME)
        next_state.rsp.readdata = {24'h0, state.deadtime};
      else if (bus_req.address[5:4] == OFS_CCR0[5:4])
        next_state.rsp.readdata = state.ccr[bus_req.address[3:2]];
    end
    if (taken && bus_req.write)
    begin
      if (bus_req.address == OFS_CONTROL)
        next_state.control = merge(state.control, bus_req.writedata, bus_req.byteenable) & 32'h1ff;
      else if (bus_req.address == OFS_PRESCALE)
        next_state.prescale = 16'(merge({16'h0, state.prescale}, bus_req.writedata,
                                        bus_req.byteenable));
      else if (bus_req.address == OFS_RELOAD)
        next_state.reload = merge(state.reload, bus_req.writedata, bus_req.byteenable);
      else if (bus_req.address == OFS_COUNT)
      begin
        next_state.count = merge(state.count, bus_req.writedata, bus_req.byteenable);
        cnt_override = 1'b1;
      end
      else if (bus_req.address == OFS_MASK && bus_req.byteenable[0])
        next_state.mask = bus_req.writedata[STAT_WIDTH-1:0];
      else if (bus_req.address == OFS_CHAN_MODE)
        next_state.chan_mode = 16'(merge({16'h0, state.chan_mode}, bus_req.writedata,
                                         bus_req.byteenable));
      else if (bus_req.address == OFS_DEADTIME && bus_req.byteenable[0])
        next_state.deadtime = bus_req.writedata[7:0];
      else if (bus_req.address[5:4] == OFS_CCR0[5:4])
        next_state.ccr[bus_req.address[3:2]] = merge(state.ccr[bus_req.address[3:2]],
                                                     bus_req.writedata, bus_req.byteenable);
    end

    // read clears only the bits it returned, so a new event is never lost
    if (taken && bus_req.read && bus_req.address == OFS_STATUS)
      next_state.status = state.status & ~state.rsp.readdata[STAT_WIDTH-1:0];
    else
      next_state.status = state.status;
    next_state.status[STAT_UPDATE] = next_state.status[STAT_UPDATE] | update_evt;
    next_state.status[STAT_CHAN_LSB +: 4] = next_state.status[STAT_CHAN_LSB +: 4] | chan_evt;
    next_state.status[STAT_TRIGGER] = next_state.status[STAT_TRIGGER]
                                      | (trig_rise && slave != SLAVE_FREE) | hall_evt;
    next_state.irq = |(next_state.status & next_state.mask);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state <= '0;
      state.control <= RST_CONTROL;
      state.prescale <= RST_PRESCALE;
      state.reload <= RST_RELOAD;
      state.deadtime <= RST_DEADTIME;
      state.rsp.waitrequest <= 1'b1;
    end
    else
      state <= next_state;
  end

  assign bus_rsp = state.rsp;
  assign out_high = state.out_high;
  assign out_low = state.out_low;
  assign trig_out = state.trig_out;
  assign conv_trig = state.conv;
  assign irq = state.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_count_wrap: assert property ((tick && !center && !down_dir && state.count >= state.reload
    && !cnt_override && !frozen) |=> state.count == 32'h0) else $error("up count did not wrap");
  a_prescale_gap: assert property ((psc_adv && state.psc_cnt < psc_eff - 16'h0001) |-> !tick
    || enc_step) else $error("tick before prescale count ends");
  a_compare_toggle: assert property ((tick && chan_evt[1] && cmode != CHAN_CAPTURE
    && state.chan_mode[5:4] == CHAN_COMPARE) |=> state.ref_level[1] != $past(state.ref_level[1]))
    else $error("compare match did not toggle");
  a_pwm_level: assert property ((state.chan_mode[13:12] == CHAN_PWM && !state.chan_mode[14]
    && state.control[CTL_ENABLE] && state.control[CTL_OUT_ENABLE] && !frozen)
    |=> out_high[3] == ($past(state.count) < $past(state.ccr[3])))
    else $error("pwm level wrong");
  a_dead_gap: assert property (($fell(out_low[0]) && state.deadtime != 8'h00) |-> !out_high[0])
    else $error("no dead time on pair 0");
  a_debug_off: assert property (frozen && !(taken && bus_req.write) |=> out_high == 4'h0
    && out_low == 3'h0 && state.count == $past(state.count)) else $error("debug halt not honoured");
  a_encoder_step: assert property ((enc_step && enc_up && tick && state.count < state.reload
    && !cnt_override && !frozen) |=> state.count == $past(state.count) + 32'h1)
    else $error("encoder step lost");
  a_hall_flag: assert property (hall_evt |=> state.status[STAT_TRIGGER] ##1 1'b1)
    else $error("hall change not flagged");
  a_chain_start: assert property ((slave == SLAVE_START && trig_rise && !(taken && bus_req.write)) |=>
    state.control[CTL_ENABLE] || $past(update_evt && state.control[CTL_ONE_PULSE]))
    else $error("trigger did not start timer");
  a_conv_route: assert property (update_evt |=> conv_trig.adc_injected ==
    (VARIANT == VARIANT_ADVANCED) && conv_trig.adc_regular == (VARIANT == VARIANT_GENERAL))
    else $error("converter trigger misrouted");
  a_basic_up: assert property ((!HAS_CHAN && tick && state.count < state.reload
    && !cnt_override) |=> state.count == $past(state.count) + 32'h1) else $error("basic not up");
  a_one_pulse: assert property ((update_evt && state.control[CTL_ONE_PULSE]
    && !(taken && bus_req.write)) |=> !state.control[CTL_ENABLE]) else $error("one pulse kept on");
  a_update_flag: assert property (update_evt |=> state.status[STAT_UPDATE] && trig_out)
    else $error("update not flagged");
  a_capture_latch: assert property ((chan_evt[2] && state.chan_mode[9:8] == CHAN_CAPTURE)
    |=> state.ccr[2] == $past(state.count) && state.status[STAT_CHAN_LSB + 2])
    else $error("capture not latched");

  c_update: cover property (update_evt ##1 irq);
  c_center_turn: cover property (center && tick && state.phase_down ##[1:50] !state.phase_down);
  c_capture: cover property (chan_evt[0] && state.chan_mode[1:0] == CHAN_CAPTURE);
  c_bus_read: cover property (taken && bus_req.read && bus_req.address == OFS_STATUS);
endmodule

// File: testbench/encoder_model.sv
module encoder_model (
  input wire logic clk, // bench clock
  output logic [3:0] pins // encoder a/b on [1:0], capture pins on [3:2]
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase = 2'h0;
  logic [1:0] extra = 2'h0;
  // gray order so only one line moves per step; forward lets a lead b
  assign pins = {extra, phase[1], phase[1] ^ phase[0]};

  // five clocks per step so the two-flop synchroniser sees every state
  task automatic step(input logic fwd, input int n);
    repeat (n)
    begin
      @(posedge clk);
      phase <= fwd ? phase + 2'h1 : phase - 2'h1;
      repeat (4) @(posedge clk);
    end
  endtask

  task automatic pulse(input int pin);
    @(posedge clk);
    extra[pin] <= 1'b1;
    repeat (6) @(posedge clk);
    extra[pin] <= 1'b0;
  endtask
endmodule

// File: testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import timer_pkg::*;
  typedef struct {logic [5:0] a; logic [31:0] d;} row_type;
  typedef struct {logic [31:0] ctl; int n; int high;} pwm_row_type;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  avalon_req_type bus_req = '0;
  avalon_rsp_type bus_rsp;
  logic [3:0] chan_in;
  logic trig_in = 1'b0;
  logic [3:0] out_high;
  logic [2:0] out_low;
  logic trig_out;
  conv_trig_type conv_trig;
  logic irq;
  int n_errors = 0;
  int check_count = 0;
  int n_regular = 0;
  int n_wrong = 0;
  logic [31:0] q;
  logic [31:0] c1;
  logic [31:0] c3;
  int h;
  row_type rows[10] = '{'{OFS_CONTROL, RST_CONTROL}, '{OFS_PRESCALE, 32'h1},
    '{OFS_RELOAD, RST_RELOAD}, '{OFS_COUNT, 32'h0}, '{OFS_STATUS, 32'h0}, '{OFS_MASK, 32'h0},
    '{OFS_CHAN_MODE, 32'h0}, '{OFS_DEADTIME, 32'h0}, '{OFS_CCR0, 32'h0}, '{6'h30, 32'h0}};
  // edge-aligned: 2 of 5 cycles high; center: 3 of 8
  pwm_row_type pwm_rows[2] = '{'{32'h101, 50, 20}, '{32'h105, 48, 18}};

  always #20 clk = ~clk;

  pwm_timer #(.VARIANT(VARIANT_GENERAL)) u_pwm_timer (.clk(clk), .sys_rst(sys_rst),
    .bus_req(bus_req), .bus_rsp(bus_rsp), .chan_in(chan_in), .trig_in(trig_in),
    .debug_halt(1'b0), .out_high(out_high), .out_low(out_low), .trig_out(trig_out),
    .conv_trig(conv_trig), .irq(irq));
  encoder_model u_encoder_model (.clk(clk), .pins(chan_in));

  always @(posedge clk)
  begin
    if (conv_trig.adc_regular === 1'b1) n_regular++;
    if (conv_trig.dac !== 1'b0 || conv_trig.adc_injected !== 1'b0) n_wrong++;
    if (trig_out !== conv_trig.adc_regular) n_wrong++;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // holds the request until waitrequest is sampled low, then one idle edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int t;
    t = 0;
    bus_req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hf};
    do
    begin
      @(posedge clk);
      t++;
    end
    while (bus_rsp.waitrequest !== 1'b0 && t < 50);
    if (t >= 50) chk("waitrequest", 32'h0, 32'h1);
    r = bus_rsp.readdata;
    bus_req.read <= 1'b0;
    bus_req.write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [5:0] a);
    bus(1'b0, a, 32'h0, q);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    test_done();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i])
    begin
      rd(rows[i].a);
      chk("reset value", rows[i].d, q);
    end
    wr(OFS_RELOAD, 32'h4);
    wr(OFS_MASK, 32'h1);
    wr(OFS_CONTROL, 32'h1);
    repeat (20) @(posedge clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(OFS_CONTROL, 32'h0);
    rd(OFS_STATUS);
    chk("update flag", 32'h1, {31'h0, q[STAT_UPDATE]});
    rd(OFS_STATUS);
    chk("flag cleared", 32'h0, {31'h0, q[STAT_UPDATE]});
    repeat (2) @(posedge clk);
    chk("irq dropped", 32'h0, {31'h0, irq});
    chk("regular trigger", 32'h1, {31'h0, n_regular > 0});
    chk("foreign triggers", 32'h0, n_wrong);
    wr(OFS_RELOAD, RST_RELOAD);
    wr(OFS_COUNT, 32'd100);
    wr(OFS_CONTROL, 32'h3);
    repeat (20) @(posedge clk);
    wr(OFS_CONTROL, 32'h0);
    rd(OFS_COUNT);
    chk("counts down", 32'h1, {31'h0, q < 100 && q > 60});
    // same bus timing both runs, so only the divide factor differs
    for (int p = 1; p <= 3; p += 2)
    begin
      wr(OFS_PRESCALE, p);
      wr(OFS_COUNT, 32'h0);
      wr(OFS_CONTROL, 32'h1);
      repeat (60) @(posedge clk);
      wr(OFS_CONTROL, 32'h0);
      rd(OFS_COUNT);
      if (p == 1) c1 = q;
      else c3 = q;
    end
    chk("prescale ratio", 32'h1, {31'h0, c1 + 3 >= 3 * c3 && c1 <= 3 * c3 + 3});
    wr(OFS_PRESCALE, 32'h1);
    wr(OFS_RELOAD, 32'h3);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_CONTROL, 32'h9);
    repeat (20) @(posedge clk);
    rd(OFS_CONTROL);
    chk("one pulse stop", 32'h0, {31'h0, q[CTL_ENABLE]});
    wr(OFS_CONTROL, {25'h0, SLAVE_START, 4'h0});
    trig_in <= 1'b1;
    repeat (6) @(posedge clk);
    trig_in <= 1'b0;
    rd(OFS_CONTROL);
    chk("trigger start", 32'h1, {31'h0, q[CTL_ENABLE]});
    wr(OFS_RELOAD, RST_RELOAD);
    wr(OFS_CONTROL, {25'h0, SLAVE_ENCODER, 4'h1});
    wr(OFS_COUNT, 32'h0);
    u_encoder_model.step(1'b1, 8);
    rd(OFS_COUNT);
    chk("encoder forward", 32'd8, q);
    u_encoder_model.step(1'b0, 3);
    rd(OFS_COUNT);
    chk("encoder back", 32'd5, q);
    wr(OFS_CONTROL, 32'h1);
    wr(OFS_CHAN_MODE, {22'h0, CHAN_CAPTURE, 8'h0});
    rd(OFS_STATUS);
    u_encoder_model.pulse(0);
    repeat (6) @(posedge clk);
    rd(OFS_STATUS);
    chk("capture flag", 32'h1, {31'h0, q[STAT_CHAN_LSB + 2]});
    rd(OFS_CCR0 + 6'h08);
    chk("capture value", 32'h1, {31'h0, q != 0});
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_CHAN_MODE, {18'h0, CHAN_PWM, 12'h0});
    wr(OFS_CCR0 + 6'h0c, 32'h2);
    wr(OFS_RELOAD, 32'h4);
    foreach (pwm_rows[i])
    begin
      wr(OFS_CONTROL, pwm_rows[i].ctl);
      repeat (10) @(posedge clk);
      h = 0;
      repeat (pwm_rows[i].n)
      begin
        @(posedge clk);
        h += int'(out_high[3] === 1'b1);
      end
      chk("pwm duty", 32'h1, {31'h0, h >= pwm_rows[i].high - 2 && h <= pwm_rows[i].high + 2});
      wr(OFS_CONTROL, 32'h0);
    end
    chk("low side off", 32'h0, {29'h0, out_low});
    wr(OFS_CHAN_MODE, 32'h0);
    wr(OFS_CONTROL, {25'h0, SLAVE_HALL, 4'h1});
    rd(OFS_STATUS);
    u_encoder_model.pulse(0);
    repeat (6) @(posedge clk);
    rd(OFS_STATUS);
    chk("hall flag", 32'h1, {31'h0, q[STAT_TRIGGER]});
    wr(OFS_CONTROL, 32'h0);
    test_done();
  end
endmodule
